// File: pkg/nvac_pkg.sv
// Package for the nonvolatile access control block: register map, field positions, timing.
// Assumes a byte-wide special function register port driven by the core.
package nvac_pkg;
    localparam int unsigned NVAC_CLK_HZ      = 10_000_000;
    // Self-timed write duration in microseconds; arbitrary default, the real limit is electrical.
    localparam int unsigned NVAC_WRITE_US    = 4000;
    localparam int unsigned NVAC_WRITE_CYC   = (NVAC_WRITE_US * (NVAC_CLK_HZ / 1_000_000));
    localparam int unsigned NVAC_READ_CYC    = 1;

    localparam logic [3:0] NVAC_ADR_TBL_UPPER = 4'h0;
    localparam logic [3:0] NVAC_ADR_TBL_HIGH  = 4'h1;
    localparam logic [3:0] NVAC_ADR_TBL_LOW   = 4'h2;
    localparam logic [3:0] NVAC_ADR_TBL_LATCH = 4'h3;
    localparam logic [3:0] NVAC_ADR_KEY       = 4'h4;
    localparam logic [3:0] NVAC_ADR_CONTROL   = 4'h5;
    localparam logic [3:0] NVAC_ADR_DATA      = 4'h6;
    localparam logic [3:0] NVAC_ADR_ADDRESS   = 4'h7;

    localparam int unsigned NVAC_B_PGM  = 7;
    localparam int unsigned NVAC_B_CFG  = 6;
    localparam int unsigned NVAC_B_FREE = 4;
    localparam int unsigned NVAC_B_ERR  = 3;
    localparam int unsigned NVAC_B_WEN  = 2;
    localparam int unsigned NVAC_B_WR   = 1;
    localparam int unsigned NVAC_B_RD   = 0;

    localparam logic [7:0] NVAC_KEY_FIRST  = 8'h55;
    localparam logic [7:0] NVAC_KEY_SECOND = 8'hAA;
    localparam logic [7:0] NVAC_ZERO       = 8'h00;
    localparam logic [4:0] NVAC_UPPER_MASK = 5'h1F;

    typedef enum logic [1:0] {
        NVAC_TGT_DATA = 2'h0,
        NVAC_TGT_PGM  = 2'h1,
        NVAC_TGT_CFG  = 2'h2
    } nvac_target_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } nvac_sfr_req_t;

    typedef struct packed {
        logic         start_write;
        logic         erase_row;
        nvac_target_t target;
        logic [20:0]  table_ptr;
        logic [7:0]   latch;
    } nvac_pgm_req_t;
endpackage

// File: hw/nvac_timer.sv
// Self-timed operation counter: runs for a fixed count after a start pulse.
// Assumes one clock and a synchronous reset.
module nvac_timer #(
    parameter int unsigned CYCLES = 40000
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] cnt_q;
    logic         busy_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else if (start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
        end else if (busy_q) begin
            if (cnt_q == LAST) begin
                busy_q <= 1'b0;
            end
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign busy = busy_q;
    assign done = busy_q && (cnt_q == LAST);
endmodule

// File: hw/nvac_array.sv
// Data EEPROM storage: 256 bytes of flip-flops, erase-before-write on commit.
// Assumes commit is a one-cycle pulse at the end of a timed write.
module nvac_array #(
    parameter int unsigned AW = 8
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          srst,
    // Access
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic          commit,
    output logic      [7:0]    rdata
);
    logic [7:0] mem_q [2**AW];

    // Erase then program collapse to one overwrite at the end of the timed write.
    always_ff @(posedge clk_sys) begin
        if (commit) begin
            mem_q[addr] <= wdata;
        end
    end

    assign rdata = mem_q[addr];
endmodule

// File: hw/nvac_ctrl.sv
// Top of the nonvolatile access control block: special function registers, unlock, sequencing.
// Assumes the core issues single-cycle SFR reads and writes on clk_sys and that
// program memory and configuration writes are carried out by logic outside this block.
module nvac_ctrl
    import nvac_pkg::*;
#(
    parameter int unsigned WRITE_CYC = nvac_pkg::NVAC_WRITE_CYC
) (
    // Clock and resets
    clk_sys,
    srst,
    external_pin_reset,
    watchdog_timeout_reset,
    // Special function register port
    sfr_req,
    sfr_rdata,
    // Program memory and configuration write path
    pgm_req,
    pgm_done,
    pgm_latch_in,
    pgm_latch_load,
    // Status
    nvm_done_flag,
    nvm_busy
);
    input  wire logic                    clk_sys;
    input  wire logic                    srst;
    input  wire logic                    external_pin_reset;
    input  wire logic                    watchdog_timeout_reset;
    input  wire nvac_pkg::nvac_sfr_req_t sfr_req;
    output logic [7:0]                   sfr_rdata;
    output nvac_pkg::nvac_pgm_req_t      pgm_req;
    input  wire logic                    pgm_done;
    input  wire logic [7:0]              pgm_latch_in;
    input  wire logic                    pgm_latch_load;
    output logic                         nvm_done_flag;
    output logic                         nvm_busy;

    typedef enum logic [2:0] {
        NVAC_ST_IDLE  = 3'b001,
        NVAC_ST_WRITE = 3'b010,
        NVAC_ST_EXT   = 3'b100
    } nvac_state_t;

    typedef enum logic [2:0] {
        NVAC_KEY_NONE = 3'b001,
        NVAC_KEY_GOT1 = 3'b010,
        NVAC_KEY_GOT2 = 3'b100
    } nvac_key_t;

    nvac_state_t  state_q;
    nvac_key_t    key_q;
    logic         pgm_sel_q;
    logic         cfg_sel_q;
    logic         free_q;
    logic         err_q;
    logic         allow_q;
    logic         wr_q;
    logic         rd_q;
    logic         done_q;
    logic [7:0]   data_q;
    logic [7:0]   addr_q;
    logic [4:0]   tbl_upper_q;
    logic [7:0]   tbl_high_q;
    logic [7:0]   tbl_low_q;
    logic [7:0]   latch_q;
    logic [7:0]   arr_rdata;
    logic         timer_start;
    logic         timer_busy;
    logic         timer_done;
    logic         any_reset;
    logic         wr_ctl;
    logic         wr_key;
    logic         set_wr;
    logic         set_rd;
    logic         wr_end;
    nvac_target_t target;

    assign any_reset = srst || external_pin_reset || watchdog_timeout_reset;
    assign wr_ctl    = sfr_req.wr && (sfr_req.addr == NVAC_ADR_CONTROL);
    assign wr_key    = sfr_req.wr && (sfr_req.addr == NVAC_ADR_KEY);

    always_comb begin
        if (cfg_sel_q) begin
            target = NVAC_TGT_CFG;
        end else if (pgm_sel_q) begin
            target = NVAC_TGT_PGM;
        end else begin
            target = NVAC_TGT_DATA;
        end
    end

    // Write starts need the allow bit, the full key and an idle engine; read starts need neither allow bit nor key.
    assign set_wr = wr_ctl && sfr_req.wdata[NVAC_B_WR] && allow_q
                    && (key_q == NVAC_KEY_GOT2)
                    && !wr_q && !rd_q;
    assign set_rd = wr_ctl && sfr_req.wdata[NVAC_B_RD] && !sfr_req.wdata[NVAC_B_PGM]
                    && !pgm_sel_q
                    && !wr_q && !rd_q && !set_wr;

    assign timer_start = set_wr && (target == NVAC_TGT_DATA);
    assign wr_end      = ((state_q == NVAC_ST_WRITE) && timer_done)
                         || ((state_q == NVAC_ST_EXT) && pgm_done);

    // Unlock sequence tracker; any other register write breaks the sequence.
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            key_q <= NVAC_KEY_NONE;
        end else if (wr_key) begin
            if (sfr_req.wdata == NVAC_KEY_FIRST) begin
                key_q <= NVAC_KEY_GOT1;
            end else if ((sfr_req.wdata == NVAC_KEY_SECOND) && (key_q == NVAC_KEY_GOT1)) begin
                key_q <= NVAC_KEY_GOT2;
            end else begin
                key_q <= NVAC_KEY_NONE;
            end
        end else if (sfr_req.wr) begin
            key_q <= NVAC_KEY_NONE;
        end
    end

    // Operation sequencer.
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            state_q <= NVAC_ST_IDLE;
        end else begin
            case (state_q)
                NVAC_ST_IDLE: begin
                    if (set_wr) begin
                        state_q <= (target == NVAC_TGT_DATA) ? NVAC_ST_WRITE : NVAC_ST_EXT;
                    end
                end
                NVAC_ST_WRITE: begin
                    if (timer_done) begin
                        state_q <= NVAC_ST_IDLE;
                    end
                end
                NVAC_ST_EXT: begin
                    if (pgm_done) begin
                        state_q <= NVAC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= NVAC_ST_IDLE;
                end
            endcase
        end
    end

    // Control register bits.
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            allow_q <= 1'b0;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            free_q  <= 1'b0;
        end else begin
            if (wr_ctl) begin
                allow_q <= sfr_req.wdata[NVAC_B_WEN];
            end
            if (set_wr) begin
                wr_q <= 1'b1;
            end else if (wr_end) begin
                wr_q <= 1'b0;
            end
            rd_q <= set_rd;
            if (wr_ctl && !wr_q) begin
                free_q <= sfr_req.wdata[NVAC_B_FREE];
            end else if (wr_end) begin
                free_q <= 1'b0;
            end
        end
    end

    // Space selects hold across resets other than power-on; they are frozen mid-operation.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pgm_sel_q <= 1'b0;
            cfg_sel_q <= 1'b0;
        end else if (wr_ctl && !wr_q) begin
            pgm_sel_q <= sfr_req.wdata[NVAC_B_PGM];
            cfg_sel_q <= sfr_req.wdata[NVAC_B_CFG];
        end
    end

    // Error flag: set by a pin or watchdog reset that lands during a write.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            err_q <= 1'b0;
        end else if ((external_pin_reset || watchdog_timeout_reset) && wr_q) begin
            err_q <= 1'b1;
        end else if (wr_ctl && !sfr_req.wdata[NVAC_B_ERR]) begin
            err_q <= 1'b0;
        end
    end

    // Done flag: hardware only sets it; a control register write leaves it unchanged.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done_q <= 1'b0;
        end else if (wr_end) begin
            done_q <= 1'b1;
        end else if (wr_ctl && !sfr_req.wdata[NVAC_B_ERR + 1]) begin
            done_q <= done_q;
        end
    end

    // Data and address registers.
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            data_q <= NVAC_ZERO;
            addr_q <= NVAC_ZERO;
        end else begin
            if (rd_q) begin
                data_q <= arr_rdata;
            end else if (sfr_req.wr && (sfr_req.addr == NVAC_ADR_DATA) && !wr_q) begin
                data_q <= sfr_req.wdata;
            end
            if (sfr_req.wr && (sfr_req.addr == NVAC_ADR_ADDRESS) && !wr_q) begin
                addr_q <= sfr_req.wdata;
            end
        end
    end

    // Table pointer and latch.
    always_ff @(posedge clk_sys) begin
        if (any_reset) begin
            tbl_upper_q <= '0;
            tbl_high_q  <= NVAC_ZERO;
            tbl_low_q   <= NVAC_ZERO;
            latch_q     <= NVAC_ZERO;
        end else begin
            if (sfr_req.wr && (sfr_req.addr == NVAC_ADR_TBL_UPPER)) begin
                tbl_upper_q <= sfr_req.wdata[4:0] & NVAC_UPPER_MASK;
            end
            if (sfr_req.wr && (sfr_req.addr == NVAC_ADR_TBL_HIGH)) begin
                tbl_high_q <= sfr_req.wdata;
            end
            if (sfr_req.wr && (sfr_req.addr == NVAC_ADR_TBL_LOW)) begin
                tbl_low_q <= sfr_req.wdata;
            end
            if (pgm_latch_load) begin
                latch_q <= pgm_latch_in;
            end else if (sfr_req.wr && (sfr_req.addr == NVAC_ADR_TBL_LATCH)) begin
                latch_q <= sfr_req.wdata;
            end
        end
    end

    always_comb begin
        sfr_rdata = NVAC_ZERO;
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                NVAC_ADR_TBL_UPPER: sfr_rdata = {3'h0, tbl_upper_q};
                NVAC_ADR_TBL_HIGH:  sfr_rdata = tbl_high_q;
                NVAC_ADR_TBL_LOW:   sfr_rdata = tbl_low_q;
                NVAC_ADR_TBL_LATCH: sfr_rdata = latch_q;
                NVAC_ADR_KEY:       sfr_rdata = NVAC_ZERO;
                NVAC_ADR_CONTROL:   sfr_rdata = {pgm_sel_q, cfg_sel_q, 1'b0, free_q,
                                                 err_q, allow_q, wr_q, rd_q};
                NVAC_ADR_DATA:      sfr_rdata = data_q;
                NVAC_ADR_ADDRESS:   sfr_rdata = addr_q;
                default:            sfr_rdata = NVAC_ZERO;
            endcase
        end
    end

    assign pgm_req.start_write = set_wr && (target != NVAC_TGT_DATA);
    assign pgm_req.erase_row   = free_q;
    assign pgm_req.target      = target;
    assign pgm_req.table_ptr   = {tbl_upper_q, tbl_high_q, tbl_low_q};
    assign pgm_req.latch       = latch_q;
    assign nvm_done_flag       = done_q;
    assign nvm_busy            = wr_q;

    nvac_timer #(
        .CYCLES (WRITE_CYC)
    ) u_timer (
        .clk_sys (clk_sys),
        .srst    (any_reset),
        .start   (timer_start),
        .busy    (timer_busy),
        .done    (timer_done)
    );

    nvac_array #(
        .AW (8)
    ) u_array (
        .clk_sys (clk_sys),
        .srst    (srst),
        .addr    (addr_q),
        .wdata   (data_q),
        .commit  ((state_q == NVAC_ST_WRITE) && timer_done),
        .rdata   (arr_rdata)
    );
endmodule

// File: tb/nvac_ctrl_chk.sv
// Checker for nvac_ctrl: watches the top module's ports only.
// Assumes one clock domain, with srst as the reset that disables the checks.
module nvac_ctrl_chk
    import nvac_pkg::*;
#(
    parameter int unsigned WRITE_CYC = 8
) (
    // Clock and resets
    input wire logic                    clk_sys,
    input wire logic                    srst,
    input wire logic                    external_pin_reset,
    input wire logic                    watchdog_timeout_reset,
    // Register port and outputs
    input wire nvac_pkg::nvac_sfr_req_t sfr_req,
    input wire logic [7:0]              sfr_rdata,
    input wire nvac_pkg::nvac_pgm_req_t pgm_req,
    input wire logic                    nvm_done_flag,
    input wire logic                    nvm_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic         first_q, armed_q, allow_q, key_wr, ctl_wr, pin_rst;
    nvac_target_t want;
    assign key_wr = sfr_req.wr && sfr_req.addr == NVAC_ADR_KEY;
    assign ctl_wr = sfr_req.wr && sfr_req.addr == NVAC_ADR_CONTROL;
    assign pin_rst = external_pin_reset || watchdog_timeout_reset;
    assign want = sfr_req.wdata[NVAC_B_CFG] ? NVAC_TGT_CFG :
                  sfr_req.wdata[NVAC_B_PGM] ? NVAC_TGT_PGM : NVAC_TGT_DATA;
    // Remembers whether the last two register writes were the unlock pair.
    always_ff @(posedge clk_sys) begin
        if (srst || pin_rst) begin
            first_q <= 1'b0;
            armed_q <= 1'b0;
            allow_q <= 1'b0;
        end else if (sfr_req.wr) begin
            first_q <= key_wr && sfr_req.wdata == NVAC_KEY_FIRST;
            armed_q <= first_q && key_wr && sfr_req.wdata == NVAC_KEY_SECOND;
            if (ctl_wr) begin
                allow_q <= sfr_req.wdata[NVAC_B_WEN];
            end
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    sequence s_unlocked;
        armed_q && allow_q && ctl_wr && !nvm_busy && !pin_rst && sfr_req.wdata[2:0] == 3'h6;
    endsequence
    sequence s_ended;
        $fell(nvm_busy) && !$past(pin_rst);
    endsequence
    chk_start_taken:
        assert property (s_unlocked |=> nvm_busy) else $error("unlocked start ignored");
    chk_start_needs_key:
        assert property ($rose(nvm_busy)
            |-> $past(armed_q && allow_q && ctl_wr && sfr_req.wdata[NVAC_B_WR]))
        else $error("start without key or allow");
    chk_busy_bounded:
        assert property ($rose(nvm_busy) && pgm_req.target == NVAC_TGT_DATA
            |-> ##[1:1000] !nvm_busy) else $error("timed write never ended");
    chk_done_on_end:
        assert property (s_ended |-> nvm_done_flag) else $error("done flag not set");
    chk_done_sticky:
        assert property (nvm_done_flag |=> nvm_done_flag) else $error("done flag cleared");
    chk_reset_aborts:
        assert property (pin_rst |=> !nvm_busy) else $error("write survived reset");
    chk_target_sel:
        assert property (ctl_wr && !nvm_busy && !pin_rst |=> pgm_req.target == $past(want))
        else $error("target select wrong");
    chk_table_write:
        assert property (sfr_req.wr && sfr_req.addr == NVAC_ADR_TBL_LOW && !pin_rst
            |=> pgm_req.table_ptr[7:0] == $past(sfr_req.wdata)) else $error("table low");
    chk_pulse_target:
        assert property (pgm_req.start_write |-> pgm_req.target != NVAC_TGT_DATA)
        else $error("program start for data target");
    chk_key_reads_zero:
        assert property (sfr_req.rd && sfr_req.addr == NVAC_ADR_KEY |-> sfr_rdata == NVAC_ZERO)
        else $error("unlock key read not zero");
endmodule
bind nvac_ctrl nvac_ctrl_chk #(.WRITE_CYC(WRITE_CYC)) nvac_ctrl_chk_inst (
    .clk_sys(clk_sys), .srst(srst), .external_pin_reset(external_pin_reset),
    .watchdog_timeout_reset(watchdog_timeout_reset), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .pgm_req(pgm_req), .nvm_done_flag(nvm_done_flag),
    .nvm_busy(nvm_busy)
);

// File: tb/testbench.sv
// Testbench for nvac_ctrl: register port tasks and sequences of accesses.
// Assumes the register map of nvac_pkg and a write time shortened to 8 cycles.
module testbench
    import nvac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clk_sys = 1'b0;
    logic          srst, ext_rst, wdt_rst, pgm_done, latch_load, saw_start = 1'b0;
    logic [7:0]    sfr_rdata, latch_in;
    logic          nvm_done_flag, nvm_busy;
    nvac_sfr_req_t req;
    nvac_pgm_req_t pgm_req;
    int            n_errors = 0;
    int            checked = 0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (pgm_req.start_write === 1'b1) saw_start <= 1'b1;
    nvac_ctrl #(.WRITE_CYC(8)) nvac_ctrl_inst (
        .clk_sys(clk_sys), .srst(srst), .external_pin_reset(ext_rst),
        .watchdog_timeout_reset(wdt_rst), .sfr_req(req), .sfr_rdata(sfr_rdata),
        .pgm_req(pgm_req), .pgm_done(pgm_done), .pgm_latch_in(latch_in),
        .pgm_latch_load(latch_load), .nvm_done_flag(nvm_done_flag), .nvm_busy(nvm_busy)
    );
    task automatic test_done;
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask
    task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        #10 chk(nm, e, sfr_rdata & m);
        @(negedge clk_sys);
        req.rd = 1'b0;
    endtask
    task automatic key;
        wr(NVAC_ADR_KEY, NVAC_KEY_FIRST);
        wr(NVAC_ADR_KEY, NVAC_KEY_SECOND);
    endtask
    task automatic busy(input logic b);
        chk("busy", {7'h00, b}, {7'h00, nvm_busy});
    endtask
    task automatic idle;
        for (int i = 0; i < 40 && nvm_busy !== 1'b0; i++) @(negedge clk_sys);
        busy(1'b0);
    endtask
    task automatic eewr(input logic [7:0] a, input logic [7:0] d);
        wr(NVAC_ADR_ADDRESS, a);
        wr(NVAC_ADR_DATA, d);
        wr(NVAC_ADR_CONTROL, 8'h04);
        key;
        wr(NVAC_ADR_CONTROL, 8'h06);
    endtask
    task automatic eerd(input logic [7:0] a, input logic [7:0] e);
        wr(NVAC_ADR_ADDRESS, a);
        wr(NVAC_ADR_CONTROL, 8'h01);
        rd("eeprom", NVAC_ADR_DATA, e, 8'hFF);
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_errors++;
        test_done;
    end
    initial begin
        req = '0;
        {srst, ext_rst, wdt_rst, pgm_done, latch_load, latch_in} = {1'b1, 12'h000};
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        for (int a = 0; a < 5; a++) rd("reset", 4'(a), 8'h00, 8'hFF);
        rd("unmapped", 4'h8, 8'h00, 8'hFF);
        wr(NVAC_ADR_TBL_UPPER, 8'hFF);
        wr(NVAC_ADR_TBL_HIGH, 8'hA5);
        wr(NVAC_ADR_TBL_LOW, 8'h3C);
        rd("upper", NVAC_ADR_TBL_UPPER, 8'h1F, 8'hFF);
        chk("ptr_hi", 8'hFD, pgm_req.table_ptr[20:13]);
        chk("ptr_lo", 8'h3C, pgm_req.table_ptr[7:0]);
        wr(NVAC_ADR_TBL_LATCH, 8'h5A);
        rd("latch", NVAC_ADR_TBL_LATCH, 8'h5A, 8'hFF);
        @(negedge clk_sys) {latch_in, latch_load} = {8'hC3, 1'b1};
        @(negedge clk_sys) latch_load = 1'b0;
        chk("latch_out", 8'hC3, pgm_req.latch);
        wr(NVAC_ADR_KEY, NVAC_KEY_FIRST);
        rd("key", NVAC_ADR_KEY, 8'h00, 8'hFF);
        // Refused starts: allow bit clear, no key, keys swapped, key pair broken.
        wr(NVAC_ADR_ADDRESS, 8'hFF);
        wr(NVAC_ADR_DATA, 8'h3C);
        key;
        wr(NVAC_ADR_CONTROL, 8'h02);
        rd("noallow", NVAC_ADR_CONTROL, 8'h00, 8'h03);
        wr(NVAC_ADR_CONTROL, 8'h06);
        busy(1'b0);
        wr(NVAC_ADR_KEY, NVAC_KEY_SECOND);
        wr(NVAC_ADR_KEY, NVAC_KEY_FIRST);
        wr(NVAC_ADR_CONTROL, 8'h06);
        busy(1'b0);
        wr(NVAC_ADR_KEY, NVAC_KEY_FIRST);
        wr(NVAC_ADR_DATA, 8'h3C);
        wr(NVAC_ADR_KEY, NVAC_KEY_SECOND);
        wr(NVAC_ADR_CONTROL, 8'h06);
        busy(1'b0);
        key;
        wr(NVAC_ADR_CONTROL, 8'h06);
        busy(1'b1);
        wr(NVAC_ADR_CONTROL, 8'h01);
        idle;
        chk("done", 8'h01, {7'h00, nvm_done_flag});
        rd("ctl", NVAC_ADR_CONTROL, 8'h00, 8'h0B);
        rd("data_kept", NVAC_ADR_DATA, 8'h3C, 8'hFF);
        eerd(8'hFF, 8'h3C);
        eewr(8'hFF, 8'hC3);
        idle;
        eewr(8'h00, 8'h5A);
        idle;
        eerd(8'hFF, 8'hC3);
        eerd(8'h00, 8'h5A);
        chk("no_pgm", 8'h00, {7'h00, saw_start});
        wr(NVAC_ADR_DATA, 8'h11);
        wr(NVAC_ADR_CONTROL, 8'h81);
        rd("pgm_rd", NVAC_ADR_CONTROL, 8'h80, 8'hC1);
        rd("pgm_nord", NVAC_ADR_DATA, 8'h11, 8'hFF);
        chk("tgt_pgm", 8'h01, {6'h00, pgm_req.target});
        wr(NVAC_ADR_CONTROL, 8'h01);
        rd("pgm_nord", NVAC_ADR_DATA, 8'h11, 8'hFF);
        wr(NVAC_ADR_CONTROL, 8'hC0);
        chk("tgt_cfg", 8'h02, {6'h00, pgm_req.target});
        wr(NVAC_ADR_CONTROL, 8'h94);
        chk("free", 8'h01, {7'h00, pgm_req.erase_row});
        key;
        wr(NVAC_ADR_CONTROL, 8'h96);
        repeat (2) @(negedge clk_sys);
        busy(1'b1);
        pgm_done = 1'b1;
        @(negedge clk_sys) pgm_done = 1'b0;
        idle;
        chk("pgm_go", 8'h01, {7'h00, saw_start});
        chk("free_clr", 8'h00, {7'h00, pgm_req.erase_row});
        wr(NVAC_ADR_CONTROL, 8'h00);
        chk("tgt_data", 8'h00, {6'h00, pgm_req.target});
        // A pin reset, then a watchdog reset, each cutting a write short.
        for (int s = 0; s < 2; s++) begin
            eewr(8'h10, 8'h77);
            @(negedge clk_sys) {ext_rst, wdt_rst} = s ? 2'b01 : 2'b10;
            @(negedge clk_sys) {ext_rst, wdt_rst} = 2'b00;
            busy(1'b0);
            rd("err", NVAC_ADR_CONTROL, 8'h08, 8'h0B);
            rd("data_clr", NVAC_ADR_DATA, 8'h00, 8'hFF);
            rd("adr_clr", NVAC_ADR_ADDRESS, 8'h00, 8'hFF);
            chk("done_kept", 8'h01, {7'h00, nvm_done_flag});
            wr(NVAC_ADR_CONTROL, 8'h00);
            rd("err_clr", NVAC_ADR_CONTROL, 8'h00, 8'h08);
        end
        test_done;
    end
endmodule
